// File: shared/acc_pkg.sv
// constants and types shared by the converter control block
package acc_pkg;
	// control register location on the special-function bus
	localparam logic [7:0] ACC_CTRL_ADDR = 8'hE8;
	localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
	// bit positions inside the control register
	localparam int ACC_BIT_ENABLE = 7;
	localparam int ACC_BIT_TRACK = 6;
	localparam int ACC_BIT_DONE = 5;
	localparam int ACC_BIT_BUSY = 4;
	localparam int ACC_BIT_WIN = 3;
	localparam int ACC_SEL_MSB = 2;
	// start source encodings
	localparam logic [2:0] ACC_SRC_SW = 3'h0;
	localparam logic [2:0] ACC_SRC_TMR0 = 3'h1;
	localparam logic [2:0] ACC_SRC_TMR2 = 3'h2;
	localparam logic [2:0] ACC_SRC_TMR3 = 3'h3;
	localparam logic [2:0] ACC_SRC_EDGE_A = 3'h4;
	localparam logic [2:0] ACC_SRC_EDGE_B = 3'h5;
	// timing in conversion-clock periods
	localparam logic [1:0] ACC_EXT_TRACK_CLKS = 2'h3;
	localparam logic [3:0] ACC_CONV_CLKS = 4'hB;
	localparam int ACC_DIV_W = 5;
	// sequencer states
	typedef enum logic [1:0] {ACC_IDLE, ACC_EXT_TRACK, ACC_CONVERT} acc_state_t;
endpackage

// File: verilog/acc_sar_clk_div.sv
// conversion clock divider: one tick every divider+1 system clocks
`timescale 1ns/100ps
`default_nettype none
module acc_sar_clk_div
	import acc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic restart,
	input wire logic run,
	input wire logic [ACC_DIV_W-1:0] divider,
	output logic tick
);
	logic [ACC_DIV_W-1:0] cntQ; // system clocks within one period

	// tick decoded from the count: a registered tick would add a cycle to the first period
	assign tick = run && cntQ == divider;

	// restart aligns the period to the start event, so the tracking extension is exact
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cntQ <= '0;
		else if (restart || !run)
			cntQ <= '0;
		else if (cntQ == divider)
			cntQ <= '0;
		else
			cntQ <= cntQ + 1'b1;
	end

	// period check: with a nonzero divider and no restart, a tick is followed by no tick in the next cycle
	AST_TICK_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (rst)
		tick && !restart && run && divider != '0 |=> !tick)
		else $error("conversion tick lasted more than one cycle");
endmodule
`default_nettype wire

// File: verilog/acc_conv_ctrl.sv
// converter control register and start/track/convert sequencer
`timescale 1ns/100ps
`default_nettype none
module acc_conv_ctrl
	import acc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrBitWrEn,
	input wire logic sfrBitVal,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	input wire logic [ACC_DIV_W-1:0] convClkDiv,
	input wire logic timer0Ovf,
	input wire logic timer2Ovf,
	input wire logic timer3Ovf,
	input wire logic startEdgeA,
	input wire logic startEdgeB,
	input wire logic windowMatch,
	output logic powerDown,
	output logic trackEn,
	output logic convertEn,
	output logic convDone
);
	// control register fields
	logic enQ;
	logic tmQ;
	logic doneQ;
	logic winQ;
	logic [2:0] selQ;
	acc_state_t stQ; // sequencer state
	acc_state_t stD;
	logic [3:0] tickCntQ; // conversion clocks within the current phase
	logic edgeAQ; // previous level of edge source a
	logic edgeBQ; // previous level of edge source b
	logic [7:0] wrMask; // bits written this cycle
	logic [7:0] wrVal; // values for those bits
	logic swStart;
	logic hwStart;
	logic startEv;
	logic sarTick;
	logic extLast;
	logic convLast;
	logic busy;

	assign busy = (stQ != ACC_IDLE);

	// merge byte writes and single-bit writes into one mask
	always_comb
	begin
		wrMask = 8'h00;
		wrVal = 8'h00;
		if (sfrWrEn && sfrAddr == ACC_CTRL_ADDR)
		begin
			wrMask = 8'hFF;
			wrVal = sfrWrData;
		end
		else if (sfrBitWrEn && sfrAddr[7:3] == ACC_CTRL_ADDR[7:3])
		begin
			// bit addresses 0xE8..0xEF map onto bits 0..7
			wrMask[sfrAddr[2:0]] = 1'b1;
			wrVal[sfrAddr[2:0]] = sfrBitVal;
		end
	end

	// start source decode; reserved codes never start
	always_comb
	begin
		case (selQ)
			ACC_SRC_TMR0: hwStart = timer0Ovf;
			ACC_SRC_TMR2: hwStart = timer2Ovf;
			ACC_SRC_TMR3: hwStart = timer3Ovf;
			ACC_SRC_EDGE_A: hwStart = startEdgeA && !edgeAQ;
			ACC_SRC_EDGE_B: hwStart = startEdgeB && !edgeBQ;
			default: hwStart = 1'b0;
		endcase
	end

	// a written 0 to busy does nothing; a 1 only counts in software mode
	assign swStart = wrMask[ACC_BIT_BUSY] && wrVal[ACC_BIT_BUSY] && selQ == ACC_SRC_SW;
	// starts while busy are dropped rather than queued
	assign startEv = enQ && !busy && (swStart || hwStart);
	assign extLast = sarTick && tickCntQ == {2'b00, ACC_EXT_TRACK_CLKS} - 4'h1;
	assign convLast = sarTick && tickCntQ == ACC_CONV_CLKS - 4'h1;

	// edge source history
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			edgeAQ <= 1'b0;
			edgeBQ <= 1'b0;
		end
		else
		begin
			edgeAQ <= startEdgeA;
			edgeBQ <= startEdgeB;
		end
	end

	// next sequencer state
	always_comb
	begin
		stD = stQ;
		case (stQ)
			ACC_IDLE:
			begin
				if (startEv)
					stD = tmQ ? ACC_EXT_TRACK : ACC_CONVERT;
			end
			ACC_EXT_TRACK:
			begin
				if (extLast)
					stD = ACC_CONVERT;
			end
			ACC_CONVERT:
			begin
				if (convLast)
					stD = ACC_IDLE;
			end
			default: stD = ACC_IDLE;
		endcase
		// dropping enable abandons any sequence in flight
		if (!enQ)
			stD = ACC_IDLE;
	end

	// sequencer and phase counter
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			stQ <= ACC_IDLE;
			tickCntQ <= 4'h0;
		end
		else
		begin
			stQ <= stD;
			if (stD != stQ)
				tickCntQ <= 4'h0;
			else if (sarTick)
				tickCntQ <= tickCntQ + 4'h1;
		end
	end

	// conversion clock restarts at each start so the periods are whole
	acc_sar_clk_div uDiv (
		.sys_clk(sys_clk),
		.rst(rst),
		.restart(startEv),
		.run(enQ && busy),
		.divider(convClkDiv),
		.tick(sarTick)
	);

	// software fields: enable, track mode and start source
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			enQ <= ACC_CTRL_RESET[ACC_BIT_ENABLE];
			tmQ <= ACC_CTRL_RESET[ACC_BIT_TRACK];
			selQ <= ACC_CTRL_RESET[ACC_SEL_MSB:0];
		end
		else
		begin
			if (wrMask[ACC_BIT_ENABLE])
				enQ <= wrVal[ACC_BIT_ENABLE];
			if (wrMask[ACC_BIT_TRACK])
				tmQ <= wrVal[ACC_BIT_TRACK];
			if (wrMask[ACC_SEL_MSB])
				selQ[2] <= wrVal[ACC_SEL_MSB];
			if (wrMask[1])
				selQ[1] <= wrVal[1];
			if (wrMask[0])
				selQ[0] <= wrVal[0];
		end
	end

	// sticky flags: a hardware set beats a same-cycle software clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			doneQ <= 1'b0;
			winQ <= 1'b0;
		end
		else
		begin
			if (stQ == ACC_CONVERT && convLast)
				doneQ <= 1'b1;
			else if (wrMask[ACC_BIT_DONE])
				doneQ <= wrVal[ACC_BIT_DONE];
			if (windowMatch)
				winQ <= 1'b1;
			else if (wrMask[ACC_BIT_WIN])
				winQ <= wrVal[ACC_BIT_WIN];
		end
	end

	// analogue controls and done pulse, registered; track and convert from the next state
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			powerDown <= 1'b1;
			trackEn <= 1'b0;
			convertEn <= 1'b0;
			convDone <= 1'b0;
		end
		else
		begin
			powerDown <= !(enQ && !(wrMask[ACC_BIT_ENABLE] && !wrVal[ACC_BIT_ENABLE]));
			// tracking covers idle while enabled and the extension, never the conversion itself
			trackEn <= enQ && stD != ACC_CONVERT;
			convertEn <= stD == ACC_CONVERT;
			convDone <= stQ == ACC_CONVERT && convLast && enQ;
		end
	end

	// read data: sampled on the read strobe, zero for any other address
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			sfrRdData <= 8'h00;
		else if (sfrRdEn && sfrAddr == ACC_CTRL_ADDR)
			sfrRdData <= {enQ, tmQ, doneQ, busy, winQ, selQ};
		else if (sfrRdEn)
			sfrRdData <= 8'h00;
	end

	// helper: conversion clocks seen during the extension
	logic [1:0] extSeenQ;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			extSeenQ <= 2'h0;
		else if (stQ != ACC_EXT_TRACK)
			extSeenQ <= 2'h0;
		else if (sarTick)
			extSeenQ <= extSeenQ + 2'h1;
	end

	sequence extToConv;
		stQ == ACC_EXT_TRACK ##1 stQ == ACC_CONVERT;
	endsequence

	sequence convEnds;
		stQ == ACC_CONVERT && convLast && enQ;
	endsequence

	AST_OFF_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
		!enQ |=> !busy && !convertEn)
		else $error("converter active while disabled");
	AST_NORMAL_START: assert property (@(posedge sys_clk) disable iff (rst)
		startEv && !tmQ |=> stQ == ACC_CONVERT && convertEn && !trackEn)
		else $error("normal mode did not convert at once");
	AST_EXT_THREE: assert property (@(posedge sys_clk) disable iff (rst)
		extToConv |-> extSeenQ == 2'h3)
		else $error("tracking extension not three conversion clocks");
	AST_EXT_TRACK: assert property (@(posedge sys_clk) disable iff (rst)
		tmQ && enQ && stQ == ACC_EXT_TRACK && $stable(stQ) |-> trackEn && !convertEn)
		else $error("not tracking during extension");
	AST_DONE_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
		convEnds |=> doneQ && !busy ##1 sfrRdData[ACC_BIT_BUSY] == 1'b0 || !$past(sfrRdEn))
		else $error("completion did not set done and clear busy");
	AST_DONE_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
		doneQ && !wrMask[ACC_BIT_DONE] |=> doneQ)
		else $error("done flag dropped without software");
	AST_BUSY_READ: assert property (@(posedge sys_clk) disable iff (rst)
		sfrRdEn && sfrAddr == ACC_CTRL_ADDR |=> sfrRdData[ACC_BIT_BUSY] == $past(busy))
		else $error("busy read does not show conversion");
	AST_SW_GATED: assert property (@(posedge sys_clk) disable iff (rst)
		!busy && !hwStart && selQ != ACC_SRC_SW |=> !busy)
		else $error("conversion started outside software mode");
	AST_WIN_SET: assert property (@(posedge sys_clk) disable iff (rst)
		windowMatch |=> winQ ##1 winQ || $past(wrMask[ACC_BIT_WIN]))
		else $error("window flag not held after match");
	AST_RESERVED: assert property (@(posedge sys_clk) disable iff (rst)
		selQ[2:1] == 2'b11 |-> !hwStart)
		else $error("reserved source started a conversion");
	AST_TOGETHER: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(busy) && enQ && $past(enQ) |-> doneQ && convDone)
		else $error("busy fell without done flag");
endmodule
`default_nettype wire

// File: verification/acc_conv_ctrl_tb.sv
// self-checking testbench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module testbench
	import acc_pkg::*;
;
	logic sys_clk, rst, sfrWrEn, sfrBitWrEn, sfrBitVal, sfrRdEn, windowMatch;
	logic [7:0] sfrAddr, sfrWrData, sfrRdData, rv;
	logic [ACC_DIV_W-1:0] convClkDiv;
	logic [4:0] srcPulse; // timer0, timer2, timer3, edge a, edge b
	logic powerDown, trackEn, convertEn, convDone;
	int errCount = 0;
	int numChecks = 0;
	int p0, p1, c, dn;

	acc_conv_ctrl i_acc_conv_ctrl (.sys_clk(sys_clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
		.sfrWrData(sfrWrData), .sfrBitWrEn(sfrBitWrEn), .sfrBitVal(sfrBitVal), .sfrRdEn(sfrRdEn),
		.sfrRdData(sfrRdData), .convClkDiv(convClkDiv), .timer0Ovf(srcPulse[0]), .timer2Ovf(srcPulse[1]),
		.timer3Ovf(srcPulse[2]), .startEdgeA(srcPulse[3]), .startEdgeB(srcPulse[4]),
		.windowMatch(windowMatch), .powerDown(powerDown), .trackEn(trackEn), .convertEn(convertEn),
		.convDone(convDone));

	// free-running 100 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			errCount++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// byte write, one-cycle strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1'b1;
		@(posedge sys_clk) #1;
		sfrWrEn = 1'b0;
	endtask

	// single-bit write, bit number in the low address bits
	task automatic bitwr(input logic [7:0] a, input logic v);
		@(posedge sys_clk) #1;
		sfrAddr = a;
		sfrBitVal = v;
		sfrBitWrEn = 1'b1;
		@(posedge sys_clk) #1;
		sfrBitWrEn = 1'b0;
	endtask

	// read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk) #1;
		sfrAddr = a;
		sfrRdEn = 1'b1;
		@(posedge sys_clk) #1;
		sfrRdEn = 1'b0;
		d = sfrRdData;
	endtask

	task automatic pulse(input logic [4:0] m);
		@(posedge sys_clk) #1;
		srcPulse = m;
		@(posedge sys_clk) #1;
		srcPulse = 5'h0_0;
	endtask

	// samples the current cycle first so a start launched just before is not missed
	task automatic waitConv(output int pre, output int conv, output int dones);
		pre = 0;
		conv = 0;
		dones = 0;
		for (int n = 0; n < 300 && !(dones > 0 && convertEn === 1'b0); n++)
		begin
			if (convertEn === 1'b1)
				conv++;
			else if (conv == 0)
				pre++;
			if (convDone === 1'b1)
				dones++;
			@(posedge sys_clk) #1;
		end
	endtask

	task automatic testReset();
		rd(8'hE8, rv);
		check(rv, ACC_CTRL_RESET);
		check(powerDown, 1'b1);
		rd(8'hBC, rv);
		check(rv, 8'h00);
		$display("reset test done");
	endtask

	task automatic testTrackModes();
		convClkDiv = 5'h0_2;
		wr(8'hE8, 8'h80);
		// power control follows the enable one edge after the write lands
		@(posedge sys_clk) #1;
		check(powerDown, 1'b0);
		bitwr(8'hEC, 1'b0);
		waitConv(p0, c, dn);
		check(c, 0);
		bitwr(8'hEC, 1'b1);
		check(trackEn, 1'b0);
		waitConv(p0, c, dn);
		check(c, 32'(ACC_CONV_CLKS) * 3);
		check(dn, 1);
		rd(8'hE8, rv);
		check(rv, 8'hA0);
		repeat (20) @(posedge sys_clk);
		rd(8'hE8, rv);
		check(rv, 8'hA0);
		bitwr(8'hED, 1'b0);
		wr(8'hE8, 8'hC0);
		check(trackEn, 1'b1);
		bitwr(8'hEC, 1'b1);
		waitConv(p1, c, dn);
		check(c, 32'(ACC_CONV_CLKS) * 3);
		check(p1 - p0, 32'(ACC_EXT_TRACK_CLKS) * 3);
		bitwr(8'hEC, 1'b1);
		rd(8'hE8, rv);
		check(rv, 8'hF0);
		waitConv(p1, c, dn);
		$display("track mode test done");
	endtask

	task automatic testSources();
		convClkDiv = 5'h0_0;
		for (int s = 1; s <= 5; s++)
		begin
			wr(8'hE8, 8'h80 | 8'(s));
			pulse(~(5'h0_1 << (s - 1)));
			waitConv(p0, c, dn);
			check(c, 0);
			pulse(5'h0_1 << (s - 1));
			waitConv(p0, c, dn);
			check(c, 32'(ACC_CONV_CLKS));
			check(dn, 1);
		end
		wr(8'hE8, 8'h86);
		pulse(5'h1_F);
		waitConv(p0, c, dn);
		check(c, 0);
		$display("start source test done");
	endtask

	task automatic testDisabled();
		// clearing the enable mid-conversion abandons it with no done flag
		wr(8'hE8, 8'h80);
		bitwr(8'hEC, 1'b1);
		bitwr(8'hEF, 1'b0);
		waitConv(p0, c, dn);
		check(dn, 0);
		rd(8'hE8, rv);
		check(rv, 8'h00);
		// a software start while disabled must be ignored
		wr(8'hE8, 8'h10);
		waitConv(p0, c, dn);
		check(c, 0);
		check(powerDown, 1'b1);
		@(posedge sys_clk) #1;
		windowMatch = 1'b1;
		@(posedge sys_clk) #1;
		windowMatch = 1'b0;
		rd(8'hE8, rv);
		check(rv, 8'h08);
		repeat (10) @(posedge sys_clk);
		rd(8'hE8, rv);
		check(rv, 8'h08);
		bitwr(8'hEB, 1'b0);
		rd(8'hE8, rv);
		check(rv, 8'h00);
		$display("disable and window test done");
	endtask

	task automatic endOfTest();
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// main sequence
	initial
	begin
		rst = 1'b1;
		{sfrWrEn, sfrBitWrEn, sfrBitVal, sfrRdEn, windowMatch} = 5'h0_0;
		{sfrAddr, sfrWrData} = 16'h0000;
		convClkDiv = 5'h0_0;
		srcPulse = 5'h0_0;
		repeat (12) @(posedge sys_clk);
		#1 rst = 1'b0;
		testReset();
		testTrackModes();
		testSources();
		testDisabled();
		endOfTest();
	end

	// hang guard, far beyond the few thousand cycles the tests need
	initial
	begin
		#200000;
		errCount++;
		endOfTest();
	end
endmodule
`default_nettype wire
